//--- card_nrz_pkg.sv
package card_nrz_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned CELL_HZ = 1250;
	localparam int unsigned E_HALF_CYC = CLK_HZ / (2 * CELL_HZ);
	localparam int unsigned SETTLE_MS = 10;
	localparam int unsigned SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;

	// ----------------------------------------------------------------
	// Step and pass geometry
	// ----------------------------------------------------------------
	localparam int unsigned STEP_BITS = 6;
	localparam int unsigned GROUP_BITS = 3;
	localparam logic [9:0] PASS_CELLS = 10'h3fe;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RESET = 1'h1;
	localparam int unsigned STATUS_STATE_LSB = 0;
	localparam int unsigned STATUS_WRITE_BIT = 5;
	localparam int unsigned STATUS_PLAY_BIT = 6;
	localparam int unsigned STATUS_FULL_BIT = 7;
	localparam int unsigned STATUS_COUNT_LSB = 16;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARMED = 5'h02,
		ST_LEAD = 5'h04,
		ST_SETTLE = 5'h08,
		ST_RUN = 5'h10
	} seq_state_e;

	// ----------------------------------------------------------------
	// Pins arriving from the calculator and the card mechanism
	// ----------------------------------------------------------------
	typedef struct packed {
		logic record_req_n;
		logic play_req_n;
		logic entry_switch;
		logic position_switch;
		logic clock_head;
		logic [2:0] read_head;
		logic [5:0] host_data;
	} pins_in_s;

	// Synchroniser reset level: both request pins released (high)
	localparam logic [13:0] PINS_IDLE = 14'h3000;

endpackage

//--- card_nrz_record_play_logic.sv
`timescale 1ns/1ns
module card_nrz_record_play_logic #(
	parameter int unsigned SETTLE_CYCLES = card_nrz_pkg::SETTLE_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire card_nrz_pkg::pins_in_s pins_in,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output logic [5:0] read_out,
	output logic step_strobe,
	output logic motor_on,
	output logic [3:0] head_drive_a,
	output logic [3:0] head_drive_b
);

	// Every assertion below runs on the system clock and rests during reset
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	card_nrz_pkg::pins_in_s pins_s;
	logic [13:0] pins_sync_vec;

	pin_sync #(
		.WIDTH(14),
		.IDLE_VALUE(card_nrz_pkg::PINS_IDLE)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in(pins_in),
		.sync_out(pins_sync_vec)
	);

	assign pins_s = card_nrz_pkg::pins_in_s'(pins_sync_vec);

	// ----------------------------------------------------------------
	// State declarations
	// ----------------------------------------------------------------
	card_nrz_pkg::seq_state_e state_reg, state_next;
	logic [16:0] settle_cnt_reg, settle_cnt_next;
	logic [12:0] div_cnt_reg, div_cnt_next;
	logic e_reg, e_next, f_reg, f_next;
	logic [2:0] write_stage_low_reg, write_stage_low_next, write_stage_high_reg, write_stage_high_next;
	logic [2:0] read_stage_low_reg, read_stage_low_next, read_stage_high_reg, read_stage_high_next;
	logic [5:0] read_out_reg, read_out_next;
	logic [9:0] cell_count_reg, cell_count_next;
	logic ctrl_enable_reg, ctrl_enable_next, strobe_reg, strobe_next, motor_reg, motor_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [3:0] drive_a_reg, drive_a_next, drive_b_reg, drive_b_next;

	// Decoded modes
	logic record_req, play_req, card_in, stage_clear, write_active, play_active, data_control, e_rise, e_fall;
	logic [3:0] track_bit;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	always_comb begin
		record_req = ctrl_enable_reg && !pins_s.record_req_n;
		play_req = ctrl_enable_reg && !pins_s.play_req_n && !record_req;
		card_in = (state_reg == card_nrz_pkg::ST_LEAD) || (state_reg == card_nrz_pkg::ST_SETTLE)
			|| (state_reg == card_nrz_pkg::ST_RUN);
		stage_clear = !((state_reg == card_nrz_pkg::ST_SETTLE) || (state_reg == card_nrz_pkg::ST_RUN));
		write_active = record_req && card_in;
		play_active = play_req && card_in;
		data_control = write_active ? f_reg : 1'h1;
	end

	// ----------------------------------------------------------------
	// Card pass sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		settle_cnt_next = settle_cnt_reg;
		case (state_reg)
			card_nrz_pkg::ST_IDLE: begin
				if (record_req || play_req) begin
					state_next = card_nrz_pkg::ST_ARMED;
				end
			end
			card_nrz_pkg::ST_ARMED: begin
				if (pins_s.entry_switch) begin
					state_next = card_nrz_pkg::ST_LEAD;
				end
			end
			card_nrz_pkg::ST_LEAD: begin
				if (pins_s.position_switch) begin
					state_next = card_nrz_pkg::ST_SETTLE;
					settle_cnt_next = '0;
				end
			end
			card_nrz_pkg::ST_SETTLE: begin
				settle_cnt_next = settle_cnt_reg + 17'h00001;
				if (settle_cnt_reg == 17'(SETTLE_CYCLES - 1)) begin
					state_next = card_nrz_pkg::ST_RUN;
				end
			end
			card_nrz_pkg::ST_RUN: begin
				state_next = card_nrz_pkg::ST_RUN;
			end
			default: begin
				state_next = card_nrz_pkg::ST_IDLE;
			end
		endcase
		if (card_in && !pins_s.entry_switch) begin
			state_next = card_nrz_pkg::ST_ARMED;
		end
		if (!(record_req || play_req)) begin
			state_next = card_nrz_pkg::ST_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// Timing chain: E from divider when writing, from clock track when reading
	// ----------------------------------------------------------------
	always_comb begin
		div_cnt_next = '0;
		e_next = 1'h0;
		if (record_req && state_reg == card_nrz_pkg::ST_RUN) begin
			e_next = e_reg;
			div_cnt_next = div_cnt_reg + 13'h0001;
			if (div_cnt_reg == 13'(card_nrz_pkg::E_HALF_CYC - 1)) begin
				div_cnt_next = '0;
				e_next = !e_reg;
			end
		end else if (play_req && pins_s.entry_switch) begin
			e_next = pins_s.clock_head;
		end
		e_rise = !e_reg && e_next;
		e_fall = e_reg && !e_next;
		f_next = f_reg;
		if (!(record_req || play_req) || !pins_s.entry_switch || (record_req && state_reg != card_nrz_pkg::ST_RUN)) begin
			f_next = 1'h0;
		end else if (e_fall) begin
			f_next = !f_reg;
		end
	end

	// ----------------------------------------------------------------
	// Write stages and head drivers
	// ----------------------------------------------------------------
	always_comb begin
		write_stage_low_next = write_stage_low_reg;
		write_stage_high_next = write_stage_high_reg;
		if (stage_clear) begin
			write_stage_low_next = '0;
			write_stage_high_next = '0;
		end else if (write_active && e_rise) begin
			write_stage_low_next = pins_s.host_data[2:0];
			if (data_control) begin
				write_stage_high_next = write_stage_low_reg;
			end else begin
				write_stage_high_next = pins_s.host_data[5:3];
			end
		end
		track_bit = {e_reg, write_stage_high_reg};
		if (write_active) begin
			drive_a_next = track_bit;
			drive_b_next = ~track_bit;
		end else begin
			drive_a_next = 4'hf;
			drive_b_next = 4'hf;
		end
	end

	// ----------------------------------------------------------------
	// Read stages and host outputs
	// ----------------------------------------------------------------
	always_comb begin
		read_stage_low_next = read_stage_low_reg;
		read_stage_high_next = read_stage_high_reg;
		read_out_next = read_out_reg;
		if (!play_active || stage_clear) begin
			read_stage_low_next = '0;
			read_stage_high_next = '0;
		end else if (e_rise) begin
			read_stage_low_next = pins_s.read_head;
			read_stage_high_next = read_stage_low_reg;
		end
		if (!play_req) begin
			read_out_next = '0;
		end else if (play_active && !stage_clear && e_fall && f_reg) begin
			read_out_next = {read_stage_high_reg, read_stage_low_reg};
		end
	end

	// ----------------------------------------------------------------
	// Pass counter, strobe and motor
	// ----------------------------------------------------------------
	always_comb begin
		cell_count_next = cell_count_reg;
		if (stage_clear) begin
			cell_count_next = '0;
		end else if (e_rise && cell_count_reg != card_nrz_pkg::PASS_CELLS) begin
			cell_count_next = cell_count_reg + 10'h001;
		end
		if (write_active) begin
			strobe_next = e_reg && f_reg;
		end else if (play_active && !stage_clear) begin
			strobe_next = e_reg;
		end else begin
			strobe_next = 1'h0;
		end
		motor_next = (record_req || play_req) && pins_s.entry_switch;
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_enable_next = ctrl_enable_reg;
		rdata_next = '0;
		if (reg_write && reg_addr == card_nrz_pkg::CTRL_OFFSET) begin
			ctrl_enable_next = reg_wdata[card_nrz_pkg::CTRL_ENABLE_BIT];
		end
		if (reg_read) begin
			case (reg_addr)
				card_nrz_pkg::CTRL_OFFSET: begin
					rdata_next[card_nrz_pkg::CTRL_ENABLE_BIT] = ctrl_enable_reg;
				end
				card_nrz_pkg::STATUS_OFFSET: begin
					rdata_next[card_nrz_pkg::STATUS_STATE_LSB +: 5] = state_reg;
					rdata_next[card_nrz_pkg::STATUS_WRITE_BIT] = write_active;
					rdata_next[card_nrz_pkg::STATUS_PLAY_BIT] = play_active;
					rdata_next[card_nrz_pkg::STATUS_FULL_BIT] = (cell_count_reg == card_nrz_pkg::PASS_CELLS);
					rdata_next[card_nrz_pkg::STATUS_COUNT_LSB +: 10] = cell_count_reg;
				end
				default: begin
					rdata_next = '0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg <= card_nrz_pkg::ST_IDLE;
			settle_cnt_reg <= '0;
			div_cnt_reg <= '0;
			e_reg <= 1'h0;
			f_reg <= 1'h0;
			write_stage_low_reg <= '0;
			write_stage_high_reg <= '0;
			read_stage_low_reg <= '0;
			read_stage_high_reg <= '0;
			read_out_reg <= '0;
			cell_count_reg <= '0;
			ctrl_enable_reg <= card_nrz_pkg::CTRL_ENABLE_RESET;
			rdata_reg <= '0;
			strobe_reg <= 1'h0;
			motor_reg <= 1'h0;
			drive_a_reg <= 4'hf;
			drive_b_reg <= 4'hf;
		end else begin
			state_reg <= state_next;
			settle_cnt_reg <= settle_cnt_next;
			div_cnt_reg <= div_cnt_next;
			e_reg <= e_next;
			f_reg <= f_next;
			write_stage_low_reg <= write_stage_low_next;
			write_stage_high_reg <= write_stage_high_next;
			read_stage_low_reg <= read_stage_low_next;
			read_stage_high_reg <= read_stage_high_next;
			read_out_reg <= read_out_next;
			cell_count_reg <= cell_count_next;
			ctrl_enable_reg <= ctrl_enable_next;
			rdata_reg <= rdata_next;
			strobe_reg <= strobe_next;
			motor_reg <= motor_next;
			drive_a_reg <= drive_a_next;
			drive_b_reg <= drive_b_next;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = rdata_reg;
	assign read_out = read_out_reg;
	assign step_strobe = strobe_reg;
	assign motor_on = motor_reg;
	assign head_drive_a = drive_a_reg;
	assign head_drive_b = drive_b_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_idle_no_current;
		!write_active |=> (head_drive_a == 4'hf) && (head_drive_b == 4'hf);
	endproperty
	a_idle_no_current: assert property (p_idle_no_current) else $error("Head current flows outside write mode");
	property p_lead_zero;
		(write_active && state_reg == card_nrz_pkg::ST_LEAD) |=> (head_drive_a[2:0] == 3'h0) && (head_drive_b[2:0] == 3'h7);
	endproperty
	a_lead_zero: assert property (p_lead_zero) else $error("Card lead not written as zero");
	property p_no_reversal_on_equal;
		write_active && $past(write_active) && $stable(write_stage_high_reg) |=> $stable(head_drive_a[2:0]);
	endproperty
	a_no_reversal_on_equal: assert property (p_no_reversal_on_equal) else $error("Drive reversed on equal bits");
	property p_settle_chain_held;
		(record_req && state_reg == card_nrz_pkg::ST_SETTLE)
			|-> !e_reg && !f_reg && (write_stage_high_reg == $past(write_stage_high_reg));
	endproperty
	a_settle_chain_held: assert property (p_settle_chain_held) else $error("Timing chain ran during settle");
	property p_f_half_rate;
		(state_reg == card_nrz_pkg::ST_RUN) && $changed(f_reg) && $past(state_reg == card_nrz_pkg::ST_RUN) |-> $fell(e_reg);
	endproperty
	a_f_half_rate: assert property (p_f_half_rate) else $error("F changed without E falling");
	property p_first_group_high;
		(write_active && !stage_clear && e_rise && !f_reg) |=> write_stage_high_reg == $past(pins_s.host_data[5:3]);
	endproperty
	a_first_group_high: assert property (p_first_group_high) else $error("Bits four to six not loaded first");
	property p_second_group_shift;
		(write_active && !stage_clear && e_rise && f_reg) |=> write_stage_high_reg == $past(write_stage_low_reg);
	endproperty
	a_second_group_shift: assert property (p_second_group_shift) else $error("Lower group not shifted up");
	property p_no_strobe_idle;
		(!write_active && !play_active) |=> !step_strobe;
	endproperty
	a_no_strobe_idle: assert property (p_no_strobe_idle) else $error("Step strobe outside a pass");
	property p_read_pairing;
		(play_active && !stage_clear && e_fall && f_reg) |=> read_out == {$past(read_stage_high_reg), $past(read_stage_low_reg)};
	endproperty
	a_read_pairing: assert property (p_read_pairing) else $error("Read step not presented as pair");
	property p_pass_limit;
		cell_count_reg == card_nrz_pkg::PASS_CELLS |=> cell_count_reg == card_nrz_pkg::PASS_CELLS || cell_count_reg == 10'h000;
	endproperty
	a_pass_limit: assert property (p_pass_limit) else $error("Cell count passed one card side");

	c_record_run: cover property (write_active && state_reg == card_nrz_pkg::ST_RUN && e_rise);
	c_play_capture: cover property (play_active && e_fall && f_reg);
	c_pass_full: cover property (cell_count_reg == card_nrz_pkg::PASS_CELLS);

endmodule

//--- card_player.sv
`timescale 1ns/1ns
// Card head model: plays one recorded step per start pulse
module card_player #(
	parameter int unsigned HALF = 50
) (
	input wire logic sys_clk,
	input wire logic start,
	input wire logic [5:0] code,
	output logic clock_head,
	output logic [2:0] read_head,
	output logic done
);
	// One cell: data set up first, then the clock track goes high and low
	task automatic play_cell(input logic [2:0] g);
		read_head <= g;
		repeat (10) @(posedge sys_clk);
		clock_head <= 1'b1;
		repeat (HALF) @(posedge sys_clk);
		clock_head <= 1'b0;
		repeat (HALF) @(posedge sys_clk);
	endtask

	// Frame of two cells; clock stands still and data inverts outside frames
	initial begin
		clock_head = 1'b0;
		read_head = 3'h0;
		done = 1'b1;
		forever begin
			@(posedge sys_clk);
			if (start === 1'b1) begin
				done <= 1'b0;
				play_cell(code[5:3]);
				play_cell(code[2:0]);
				read_head <= ~code[2:0];
				done <= 1'b1;
			end
		end
	end
endmodule

//--- pin_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for asynchronous pin levels
module pin_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE_VALUE = '0
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// First stage feeds only the second stage
	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	// Register both stages
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_reg <= IDLE_VALUE; // Idle pin level, so no false request follows reset
			sync_reg <= IDLE_VALUE;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;

endmodule

//--- testbench.sv
`timescale 1ns/1ns
// Self-checking bench for the card record and play logic
module testbench;
	localparam int unsigned SETTLE = 40;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic rec_n = 1'b1;
	logic play_n = 1'b1;
	logic entry = 1'b0;
	logic pos = 1'b0;
	logic [5:0] host = 6'h33;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic start = 1'b0;
	logic [5:0] code = 6'h0;
	logic clock_head;
	logic done;
	logic [2:0] read_head;
	logic [31:0] reg_rdata;
	logic [5:0] read_out;
	logic step_strobe;
	logic motor_on;
	logic [3:0] head_drive_a;
	logic [3:0] head_drive_b;
	card_nrz_pkg::pins_in_s pins_in;
	int fail_count = 0;
	int n_checks = 0;
	logic [31:0] rd;

	// ----------------------------------------------------------------
	// Clock, pins and instances
	// ----------------------------------------------------------------
	always #50 sys_clk = ~sys_clk;
	assign pins_in = {rec_n, play_n, entry, pos, clock_head, read_head, host};

	card_nrz_record_play_logic #(.SETTLE_CYCLES(SETTLE)) uut (.sys_clk(sys_clk), .reset(reset),
		.pins_in(pins_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .read_out(read_out), .step_strobe(step_strobe),
		.motor_on(motor_on), .head_drive_a(head_drive_a), .head_drive_b(head_drive_b));
	card_player #(.HALF(10)) heads (.sys_clk(sys_clk), .start(start), .code(code),
		.clock_head(clock_head), .read_head(read_head), .done(done));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#1;
		end
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask
	task bound(input int i, input int lim);
		if (i >= lim) begin
			$display("wrong value wait_bound expected below %0d seen %0d", lim, i);
			fail_count++;
			report_and_stop();
		end
	endtask
	task reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task reg_rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	task play_step(input logic [5:0] c);
		int i;
		@(posedge sys_clk);
		code <= c;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		#1;
		for (i = 0; i < 500 && done !== 1'b1; i++) tick(1);
		bound(i, 500);
		tick(5);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task test_reset();
		chk("drive_a", 32'hf, head_drive_a);
		chk("drive_b", 32'hf, head_drive_b);
		chk("motor", 32'h0, motor_on);
		chk("strobe", 32'h0, step_strobe);
		reg_rd(card_nrz_pkg::CTRL_OFFSET);
		chk("ctrl", 32'h1, rd);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("status", 32'h1, rd);
		reg_rd(4'h8);
		chk("unmapped", 32'h0, rd);
		tick(1);
		chk("rdata after", 32'h0, reg_rdata);
		$display("reset test done");
	endtask

	task test_write();
		int i;
		logic held;
		held = 1'b1;
		@(posedge sys_clk);
		rec_n <= 1'b0;
		tick(10);
		chk("armed drive", 32'hf, head_drive_a);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("armed", 32'h2, rd & 32'h1f);
		@(posedge sys_clk);
		entry <= 1'b1;
		tick(10);
		chk("lead a", 32'h0, head_drive_a[2:0]);
		chk("lead b", 32'h7, head_drive_b[2:0]);
		chk("write motor", 32'h1, motor_on);
		@(posedge sys_clk);
		pos <= 1'b1;
		tick(5);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("settle", 32'h8, rd & 32'h1f);
		tick(SETTLE);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("run", 32'h10, rd & 32'h1f);
		for (i = 0; i < 4100 && head_drive_a[2:0] !== 3'h6; i++) tick(1);
		bound(i, 4100);
		chk("cell1 b", 32'h1, head_drive_b[2:0]);
		chk("clock track", 32'h1, head_drive_a[3]);
		chk("strobe f low", 32'h0, step_strobe);
		for (i = 0; i < 9000 && head_drive_a[2:0] !== 3'h3; i++) begin
			tick(1);
			if (head_drive_a[1] !== 1'b1) held = 1'b0;
		end
		bound(i, 9000);
		chk("cell spacing", 32'h1f40, i);
		chk("held level", 32'h1, held);
		tick(2);
		chk("step strobe", 32'h1, step_strobe);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("write status", 32'h0002_0030, rd);
		@(posedge sys_clk);
		entry <= 1'b0;
		tick(5);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("entry drop", 32'h2, rd & 32'h1f);
		@(posedge sys_clk);
		rec_n <= 1'b1;
		pos <= 1'b0;
		tick(5);
		chk("off a", 32'hf, head_drive_a);
		chk("off b", 32'hf, head_drive_b);
		chk("off motor", 32'h0, motor_on);
		$display("write test done");
	endtask

	task test_read();
		int k;
		reg_wr(card_nrz_pkg::CTRL_OFFSET, 32'h0);
		@(posedge sys_clk);
		play_n <= 1'b0;
		entry <= 1'b1;
		tick(10);
		chk("disabled motor", 32'h0, motor_on);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("disabled", 32'h1, rd & 32'h1f);
		reg_wr(card_nrz_pkg::CTRL_OFFSET, 32'h1);
		tick(10);
		chk("read motor", 32'h1, motor_on);
		chk("read drive a", 32'hf, head_drive_a);
		chk("read drive b", 32'hf, head_drive_b);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("read active", 32'h1, rd[6]);
		@(posedge sys_clk);
		pos <= 1'b1;
		tick(5);
		play_step(6'h34);
		chk("step one", 32'h34, read_out);
		play_step(6'h0b);
		chk("step two", 32'h0b, read_out);
		// Rest of one card side, then one step beyond it: the cell count stops at a full side
		for (k = 2; k < 511; k++) begin
			play_step(k[5:0]);
			chk("pass step", {26'h0, k[5:0]}, read_out);
		end
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("pass full", 32'h03fe_00d0, rd);
		play_step(6'h2a);
		reg_rd(card_nrz_pkg::STATUS_OFFSET);
		chk("pass saturate", 32'h03fe_00d0, rd);
		chk("step after full", 32'h2a, read_out);
		@(posedge sys_clk);
		play_n <= 1'b1;
		entry <= 1'b0;
		pos <= 1'b0;
		tick(10);
		chk("read cleared", 32'h0, read_out);
		chk("read stop", 32'h0, motor_on);
		$display("read test done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		tick(5);
		test_reset();
		test_write();
		test_read();
		report_and_stop();
	end
endmodule
